// [src/lkscan_pkg.sv]
// shared constants and types for the key scan and read handshake block
package lkscan_pkg;
	localparam int SEG_BITS_THIRD = 126;
	localparam int SEG_BITS_QUARTER = 164;
	localparam int SEG_BITS_MAX = 164;
	localparam int PARTS_THIRD = 3;
	localparam int PARTS_QUARTER = 4;
	localparam int PART_BITS_THIRD = 42;
	localparam int PART_BITS_QUARTER = 41;
	localparam int KEY_BITS = 30;
	localparam int SCAN_ONE_T = 615;
	localparam int SCAN_TWO_T = 1230;
	localparam logic [7:0] KEY_READ_ADDR = 8'h43;
	localparam logic [10:0] SCAN_CNT_RST = 11'h000;

	typedef enum logic [1:0] {LKS_IDLE, LKS_SCAN1, LKS_SCAN2, LKS_READY} lks_state_t;

	typedef struct packed {
		lks_state_t st;
		logic [10:0] cnt;
		logic [KEY_BITS-1:0] first;
		logic [KEY_BITS-1:0] result;
		logic key_req;
		logic valid;
		logic out_q;
		logic out_en_q;
		logic [SEG_BITS_MAX-1:0] image;
		logic [2:0] part;
		logic img_done;
	} lks_state_rec_t;
endpackage

// [src/lkscan_core.sv]
// key scan timing, key request handshake and display image assembly
module lkscan_core #(
	parameter int KEY_BITS = lkscan_pkg::KEY_BITS
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// scanner side
	input wire logic scan_tick,
	input wire logic key_any,
	input wire logic [KEY_BITS-1:0] key_matrix,
	// serial side, bytes already deserialised
	input wire logic ce_n,
	input wire logic addr_valid,
	input wire logic [7:0] addr_byte,
	input wire logic read_done,
	input wire logic part_valid,
	input wire logic [5:0] part_bits_n,
	input wire logic [41:0] part_data,
	input wire logic quarter_duty,
	// key data out, open drain
	output logic data_out_o,
	output logic data_out_oe,
	output logic key_valid,
	output logic [KEY_BITS-1:0] key_data,
	// display image
	output logic [lkscan_pkg::SEG_BITS_MAX-1:0] seg_image,
	output logic seg_image_done
);
	lkscan_pkg::lks_state_rec_t s_q, s_d;
	logic [2:0] last_part;
	logic [7:0] offs;

	// key read address decode, shared by logic and checks
	function automatic logic key_read_hit(input logic vld, input logic [7:0] code);
		return vld && code == lkscan_pkg::KEY_READ_ADDR;
	endfunction

	// index of the closing part for the selected duty
	function automatic logic [2:0] part_last(input logic qd);
		if (qd) begin
			return 3'(lkscan_pkg::PARTS_QUARTER - 1);
		end
		return 3'(lkscan_pkg::PARTS_THIRD - 1);
	endfunction

	// first image bit of a part for the selected duty
	function automatic logic [7:0] part_offset(input logic qd, input logic [2:0] idx);
		if (qd) begin
			return 8'(idx * lkscan_pkg::PART_BITS_QUARTER);
		end
		return 8'(idx * lkscan_pkg::PART_BITS_THIRD);
	endfunction

	// image size for the selected duty
	function automatic int image_bits(input logic qd);
		if (qd) begin
			return lkscan_pkg::SEG_BITS_QUARTER;
		end
		return lkscan_pkg::SEG_BITS_THIRD;
	endfunction

	// last count of a scan pass of the given length
	function automatic logic pass_end(input logic [10:0] cnt, input int periods);
		return cnt == 11'(periods - 1);
	endfunction

	always_comb begin
		s_d = s_q;
		last_part = part_last(quarter_duty);
		offs = part_offset(quarter_duty, s_q.part);
		s_d.img_done = 1'b0;
		if (part_valid) begin
			for (int i = 0; i < lkscan_pkg::PART_BITS_THIRD; i++) begin
				if (i < int'(part_bits_n) && int'(offs) + i < image_bits(quarter_duty)) begin
					s_d.image[int'(offs) + i] = part_data[i];
				end
			end
			// wrap also when duty drops mid image
			if (s_q.part >= last_part) begin
				s_d.part = 3'h0;
				s_d.img_done = 1'b1;
			end else begin
				s_d.part = s_q.part + 3'h1;
			end
		end
		case (s_q.st)
			lkscan_pkg::LKS_IDLE: begin
				if (scan_tick && key_any && !s_q.key_req) begin
					s_d.st = lkscan_pkg::LKS_SCAN1;
					s_d.cnt = lkscan_pkg::SCAN_CNT_RST;
					s_d.first = key_matrix;
				end
			end
			lkscan_pkg::LKS_SCAN1: begin
				if (scan_tick) begin
					s_d.cnt = s_q.cnt + 11'h001;
					if (pass_end(s_q.cnt, lkscan_pkg::SCAN_ONE_T)) begin
						if (key_matrix == s_q.first) begin
							s_d.st = lkscan_pkg::LKS_READY;
							s_d.result = key_matrix;
						end else begin
							s_d.st = lkscan_pkg::LKS_SCAN2;
							s_d.first = key_matrix;
						end
					end
				end
			end
			lkscan_pkg::LKS_SCAN2: begin
				if (scan_tick) begin
					s_d.cnt = s_q.cnt + 11'h001;
					if (pass_end(s_q.cnt, lkscan_pkg::SCAN_TWO_T)) begin
						s_d.st = lkscan_pkg::LKS_READY;
						s_d.result = key_matrix;
					end
				end
			end
			lkscan_pkg::LKS_READY: begin
				s_d.key_req = 1'b1;
				s_d.st = lkscan_pkg::LKS_IDLE;
			end
			default: s_d.st = lkscan_pkg::LKS_IDLE;
		endcase
		if (key_read_hit(addr_valid, addr_byte)) begin
			s_d.valid = s_q.key_req;
		end
		if (read_done && s_q.key_req) begin
			s_d.key_req = 1'b0;
		end
		s_d.out_en_q = s_d.key_req && !ce_n;
		s_d.out_q = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_out_o = s_q.out_q;
	assign data_out_oe = s_q.out_en_q;
	assign key_valid = s_q.valid;
	assign key_data = s_q.result;
	assign seg_image = s_q.image;
	assign seg_image_done = s_q.img_done;

	sequence scan_begin;
		s_q.st == lkscan_pkg::LKS_IDLE && scan_tick && key_any && !s_q.key_req;
	endsequence
	sequence scan_match;
		s_q.st == lkscan_pkg::LKS_SCAN1 && scan_tick
			&& pass_end(s_q.cnt, lkscan_pkg::SCAN_ONE_T)
			&& key_matrix == s_q.first;
	endsequence
	sequence scan_differ;
		s_q.st == lkscan_pkg::LKS_SCAN1 && scan_tick
			&& pass_end(s_q.cnt, lkscan_pkg::SCAN_ONE_T)
			&& key_matrix != s_q.first;
	endsequence
	sequence rescan_end;
		s_q.st == lkscan_pkg::LKS_SCAN2 && scan_tick
			&& pass_end(s_q.cnt, lkscan_pkg::SCAN_TWO_T);
	endsequence
	sequence read_taken;
		read_done && s_q.key_req && s_q.st != lkscan_pkg::LKS_READY;
	endsequence

	a_scan_start: assert property (@(posedge clk) disable iff (sys_rst)
		scan_begin |=> s_q.st == lkscan_pkg::LKS_SCAN1
			&& s_q.cnt == lkscan_pkg::SCAN_CNT_RST)
		else $error("key scan did not start");
	a_scan_fast_ready: assert property (@(posedge clk) disable iff (sys_rst)
		scan_match |=> s_q.st == lkscan_pkg::LKS_READY ##1 s_q.key_req)
		else $error("matched scan did not finish at 615");
	a_scan_one_bound: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == lkscan_pkg::LKS_SCAN1 |-> s_q.cnt < 11'(lkscan_pkg::SCAN_ONE_T))
		else $error("first scan ran past 615");
	a_scan_retry: assert property (@(posedge clk) disable iff (sys_rst)
		scan_differ |=> s_q.st == lkscan_pkg::LKS_SCAN2)
		else $error("mismatched scan did not rerun");
	a_scan_two_ready: assert property (@(posedge clk) disable iff (sys_rst)
		rescan_end |=> s_q.st == lkscan_pkg::LKS_READY ##1 s_q.key_req)
		else $error("rescan did not finish at 1230");
	a_scan_two_end: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == lkscan_pkg::LKS_SCAN2 |-> s_q.cnt < 11'(lkscan_pkg::SCAN_TWO_T))
		else $error("rescan ran past 1230");
	a_out_low_req: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.key_req && !ce_n && !(read_done) |=> data_out_oe && !data_out_o)
		else $error("key request not shown low");
	a_ce_high_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		ce_n |=> !data_out_oe)
		else $error("key line pulled while chip enable high");
	a_out_release: assert property (@(posedge clk) disable iff (sys_rst)
		read_taken |=> !data_out_oe)
		else $error("output not released after read");
	a_out_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!s_q.key_req && s_q.st != lkscan_pkg::LKS_READY |=> !data_out_oe)
		else $error("output pulled with no scan result");
	a_busy_no_scan: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.key_req && s_q.st == lkscan_pkg::LKS_IDLE |=> s_q.st == lkscan_pkg::LKS_IDLE)
		else $error("scan started while request pending");
	a_result_hold: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.key_req |=> $stable(key_data))
		else $error("key data changed while request pending");
	a_read_valid: assert property (@(posedge clk) disable iff (sys_rst)
		key_read_hit(addr_valid, addr_byte) |=> key_valid == $past(s_q.key_req))
		else $error("key valid flag wrong");
	a_valid_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!key_read_hit(addr_valid, addr_byte) |=> $stable(key_valid))
		else $error("key valid flag changed without read");
	a_img_third: assert property (@(posedge clk) disable iff (sys_rst)
		part_valid && !quarter_duty && s_q.part == 3'(lkscan_pkg::PARTS_THIRD - 1)
		|=> seg_image_done && s_q.part == 3'h0)
		else $error("third duty image not closed at part three");
	a_img_quarter: assert property (@(posedge clk) disable iff (sys_rst)
		part_valid && quarter_duty && s_q.part == 3'(lkscan_pkg::PARTS_QUARTER - 1)
		|=> seg_image_done && s_q.part == 3'h0)
		else $error("quarter duty image not closed at part four");
	a_image_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!part_valid |=> $stable(seg_image))
		else $error("image changed without a part");
	a_done_single: assert property (@(posedge clk) disable iff (sys_rst)
		seg_image_done |-> $past(part_valid))
		else $error("image done without a closing part");
endmodule

// [testbench/lkscan_host.sv]
// controller model: watches the key line and reads key data
module lkscan_host (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// key line, pulled up; bench request for a blind read
	input wire logic line,
	input wire logic rd_any,
	// serial side
	output logic ce_n,
	output logic addr_valid,
	output logic [7:0] addr_byte,
	output logic read_done
);
	timeunit 1ns;
	timeprecision 1ns;
	// holdoff after a read, longer than the rescan time
	localparam logic [10:0] HOLD_CYC = 11'h4D8;
	logic [1:0] ph_q;
	logic [10:0] hold_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ph_q <= 2'h0;
			hold_q <= 11'h000;
		end else if (ph_q == 2'h1) begin
			ph_q <= 2'h2;
		end else if (ph_q == 2'h2) begin
			ph_q <= 2'h0;
			hold_q <= HOLD_CYC;
		end else if (hold_q != 11'h000) begin
			hold_q <= hold_q - 11'h001;
		end else if (!line || rd_any) begin
			ph_q <= 2'h1;
		end
	end
	assign ce_n = ph_q != 2'h0;
	assign addr_valid = ph_q == 2'h1;
	assign addr_byte = addr_valid ? lkscan_pkg::KEY_READ_ADDR : 8'h00;
	assign read_done = ph_q == 2'h2;
endmodule

// [testbench/lkscan_bench.sv]
// bench for the key scan, key read and image assembly
module lcd_key_scan_read_handshake_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, sys_rst = 1, key_any = 0, part_valid = 0, quarter_duty = 0, rd_any = 0;
	logic ce_n, addr_valid, read_done, data_out_o, data_out_oe, key_valid, seg_image_done;
	logic [7:0] addr_byte;
	logic [5:0] part_bits_n = 6'h2A;
	logic [41:0] part_data = 42'h0;
	logic [29:0] key_matrix = 30'h0, key_data;
	logic [163:0] seg_image;
	int miscompares = 0, compares = 0;
	initial forever #25 clk = ~clk;
	lkscan_core uut (.clk(clk), .sys_rst(sys_rst), .scan_tick(1'b1), .key_any(key_any),
		.key_matrix(key_matrix), .ce_n(ce_n), .addr_valid(addr_valid), .addr_byte(addr_byte),
		.read_done(read_done), .part_valid(part_valid), .part_bits_n(part_bits_n),
		.part_data(part_data), .quarter_duty(quarter_duty), .data_out_o(data_out_o),
		.data_out_oe(data_out_oe), .key_valid(key_valid), .key_data(key_data),
		.seg_image(seg_image), .seg_image_done(seg_image_done));
	lkscan_host host (.clk(clk), .sys_rst(sys_rst), .line(data_out_oe ? data_out_o : 1'b1),
		.rd_any(rd_any), .ce_n(ce_n), .addr_valid(addr_valid), .addr_byte(addr_byte),
		.read_done(read_done));
	task chk(input logic [163:0] seen, input logic [163:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) begin
			@(posedge clk);
			#5;
		end
	endtask
	task scan(input logic mism);
		int n;
		n = 0;
		key_matrix = 30'h2AAAAAAA;
		key_any = 1;
		while (data_out_oe !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
			if (mism && n == 300) key_matrix = 30'h15555555;
		end
		key_any = 0;
		chk(n >= (mism ? 1230 : 615) && n <= (mism ? 1236 : 621), 1);
		chk(key_data, key_matrix);
		chk(data_out_o, 0);
		tick(2);
		chk(data_out_oe, 0);
		tick(3);
		chk(key_valid, 1);
		chk(data_out_oe, 0);
		tick(20);
		$display("scan test done, mismatch=%0d", mism);
	endtask
	task img(input logic q);
		logic [163:0] exp, m;
		int w, n;
		exp = 0;
		m = 0;
		n = 0;
		w = q ? 41 : 42;
		quarter_duty = q;
		part_bits_n = 6'(w);
		for (int p = 0; p < (q ? 4 : 3); p++) begin
			part_data = 42'h2AAAAAAAAAA ^ 42'(p * 7);
			for (int b = 0; b < w; b++) begin
				exp[p * w + b] = part_data[b];
				m[p * w + b] = 1'b1;
			end
			part_valid = 1;
			tick(1);
			part_valid = 0;
			if (p < (q ? 3 : 2)) tick(1);
		end
		while (seg_image_done !== 1'b1 && n < 4) begin
			tick(1);
			n++;
		end
		chk(seg_image_done, 1);
		chk(seg_image & m, exp);
		tick(3);
		$display("image test done, quarter=%0d", q);
	endtask
	task bad_read;
		int n;
		n = 0;
		rd_any = 1;
		while (addr_valid !== 1'b1 && n < 1500) begin
			tick(1);
			n++;
		end
		rd_any = 0;
		chk(addr_valid, 1);
		tick(2);
		chk(key_valid, 0);
		chk(data_out_oe, 0);
		$display("blind read test done");
	endtask
	task rst_mid;
		sys_rst = 1;
		tick(2);
		chk(data_out_oe, 0);
		chk(key_valid, 0);
		chk(key_data, 0);
		chk(seg_image, 0);
		sys_rst = 0;
		tick(2);
		chk(seg_image_done, 0);
		chk(data_out_oe, 0);
		$display("mid run reset test done");
	endtask
	task complete_run;
		$display("comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		tick(6);
		sys_rst = 0;
		tick(2);
		scan(0);
		scan(1);
		bad_read();
		img(0);
		img(1);
		rst_mid();
		complete_run();
	end
	initial begin
		#1500000;
		miscompares++;
		complete_run();
	end
endmodule
